// *** design/tpo_top.sv ***
// module: timed pattern output register file and next-data transfer
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module tpo_top
	import tpo_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [3:0]  chan_match,
	output logic      [7:0]  lower_port_data,
	output logic      [7:0]  upper_port_data
);

	typedef struct packed {
		logic [7:0] trig_select;
		logic [7:0] rdata;
	} tpo_top_t;

	tpo_top_t s_q;
	tpo_top_t s_d;

	logic [3:0] grp_fire;
	logic [7:0] nd_lo;
	logic [7:0] nd_up;
	logic [7:0] en_lo;
	logic [7:0] en_up;
	logic       same_lo;
	logic       same_up;
	logic       w_lo_hi;
	logic       w_lo_lo;
	logic       w_up_hi;
	logic       w_up_lo;
	logic [7:0] nd_lo_wdata;
	logic [7:0] nd_up_wdata;

	// ----------------------------------------------------------------
	// shared-trigger detection per pair of groups
	// ----------------------------------------------------------------
	assign same_lo = (s_q.trig_select[3:2] == s_q.trig_select[1:0]);
	assign same_up = (s_q.trig_select[7:6] == s_q.trig_select[5:4]);

	// ----------------------------------------------------------------
	// next-data write steering by layout
	// ----------------------------------------------------------------
	always_comb
	begin
		w_up_hi = reg_wr && (reg_addr == TPO_ADDR_ND_UP_1ST);
		w_up_lo = reg_wr && (reg_addr == (same_up ? TPO_ADDR_ND_UP_1ST
		                                          : TPO_ADDR_ND_UP_2ND));
		w_lo_hi = reg_wr && (reg_addr == TPO_ADDR_ND_LO_1ST);
		w_lo_lo = reg_wr && (reg_addr == (same_lo ? TPO_ADDR_ND_LO_1ST
		                                          : TPO_ADDR_ND_LO_2ND));
		// in split layout the companion's low nibble feeds the low group
		nd_up_wdata = reg_wdata;
		nd_lo_wdata = reg_wdata;
	end

	tpo_trig_sel u_sel (
		.trig_select (s_q.trig_select),
		.chan_match  (chan_match),
		.grp_fire    (grp_fire)
	);

	tpo_half u_lower (
		.mclk      (mclk),
		.rstn      (rstn),
		.grp_fire  (grp_fire[1:0]),
		.nd_we_hi  (w_lo_hi),
		.nd_we_lo  (w_lo_lo),
		.nd_wdata  (nd_lo_wdata),
		.en_we     (reg_wr && (reg_addr == TPO_ADDR_EN_LOWER)),
		.port_we   (reg_wr && (reg_addr == TPO_ADDR_PORT_LOWER)),
		.wdata     (reg_wdata),
		.next_data (nd_lo),
		.enable    (en_lo),
		.port_data (lower_port_data)
	);

	tpo_half u_upper (
		.mclk      (mclk),
		.rstn      (rstn),
		.grp_fire  (grp_fire[3:2]),
		.nd_we_hi  (w_up_hi),
		.nd_we_lo  (w_up_lo),
		.nd_wdata  (nd_up_wdata),
		.en_we     (reg_wr && (reg_addr == TPO_ADDR_EN_UPPER)),
		.port_we   (reg_wr && (reg_addr == TPO_ADDR_PORT_UPPER)),
		.wdata     (reg_wdata),
		.next_data (nd_up),
		.enable    (en_up),
		.port_data (upper_port_data)
	);

	// ----------------------------------------------------------------
	// trigger select write and read mux
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		if (reg_wr && (reg_addr == TPO_ADDR_TRIG_SEL))
			s_d.trig_select = reg_wdata;
		// read data stands one cycle only
		s_d.rdata = TPO_UNMAPPED_READ;
		if (reg_rd)
		begin
			case (reg_addr)
				TPO_ADDR_TRIG_SEL:   s_d.rdata = s_q.trig_select;
				TPO_ADDR_EN_UPPER:   s_d.rdata = en_up;
				TPO_ADDR_EN_LOWER:   s_d.rdata = en_lo;
				TPO_ADDR_ND_UP_1ST:  s_d.rdata = same_up ? nd_up
				                                         : {nd_up[7:4], TPO_RSVD_NIBBLE};
				TPO_ADDR_ND_UP_2ND:  s_d.rdata = same_up ? TPO_RSVD_READ
				                                         : {TPO_RSVD_NIBBLE, nd_up[3:0]};
				TPO_ADDR_ND_LO_1ST:  s_d.rdata = same_lo ? nd_lo
				                                         : {nd_lo[7:4], TPO_RSVD_NIBBLE};
				TPO_ADDR_ND_LO_2ND:  s_d.rdata = same_lo ? TPO_RSVD_READ
				                                         : {TPO_RSVD_NIBBLE, nd_lo[3:0]};
				TPO_ADDR_PORT_LOWER: s_d.rdata = lower_port_data;
				TPO_ADDR_PORT_UPPER: s_d.rdata = upper_port_data;
				default:             s_d.rdata = TPO_UNMAPPED_READ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers; reset stands in for hardware standby too
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			s_q.trig_select <= TPO_RST_TRIG_SEL;
			s_q.rdata       <= TPO_UNMAPPED_READ;
		end
		else
			s_q <= s_d;
	end

	assign reg_rdata = s_q.rdata;

endmodule : tpo_top
`default_nettype wire

// *** design/tpo_pkg.sv ***
// package: register map, field layout and reset values of the timed pattern output block
// Function
// - upper next-data copied on group match
// - upper next-data resets to zero only
// - shared trigger: whole upper next-data at first
// - shared trigger: companion address reads ones
// - split trigger: group 3 first, 2 companion
// - split trigger: unused nibbles read ones
// - lower enable bits gate lower copies
// - disabled lower bit keeps port value
// - upper enable bits gate upper copies
// - disabled upper bit keeps port value
// - enable registers reset to zero
// - trigger select resets to all ones
// - bits 7:6 pick group 3 channel
// - bits 5:4 pick group 2 channel
// - bits 3:2 pick group 1 channel
// - bits 1:0 pick group 0 channel
// - lower next-data uses same address scheme
// - enabled port bits are software read-only
package tpo_pkg;

	// ----------------------------------------------------------------
	// register addresses (low 16 bits of the byte address)
	// ----------------------------------------------------------------
	localparam logic [15:0] TPO_ADDR_TRIG_SEL   = 16'hFFA1;
	localparam logic [15:0] TPO_ADDR_EN_UPPER   = 16'hFFA2;
	localparam logic [15:0] TPO_ADDR_EN_LOWER   = 16'hFFA3;
	localparam logic [15:0] TPO_ADDR_ND_UP_1ST  = 16'hFFA4;
	localparam logic [15:0] TPO_ADDR_ND_LO_1ST  = 16'hFFA5;
	localparam logic [15:0] TPO_ADDR_ND_UP_2ND  = 16'hFFA6;
	localparam logic [15:0] TPO_ADDR_ND_LO_2ND  = 16'hFFA7;
	localparam logic [15:0] TPO_ADDR_PORT_LOWER = 16'hFFB0;
	localparam logic [15:0] TPO_ADDR_PORT_UPPER = 16'hFFB1;

	// ----------------------------------------------------------------
	// reset values and fixed read values
	// ----------------------------------------------------------------
	localparam logic [7:0] TPO_RST_NEXT_DATA = 8'h00;
	localparam logic [7:0] TPO_RST_ENABLE    = 8'h00;
	localparam logic [7:0] TPO_RST_TRIG_SEL  = 8'hFF;
	localparam logic [7:0] TPO_RST_PORT      = 8'h00;
	localparam logic [7:0] TPO_RSVD_READ     = 8'hFF;
	localparam logic [3:0] TPO_RSVD_NIBBLE   = 4'hF;
	localparam logic [7:0] TPO_UNMAPPED_READ = 8'h00;

	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int TPO_NUM_GROUPS = 4;
	localparam int TPO_NUM_CHAN   = 4;
	localparam int TPO_SEL_WIDTH  = 2;
	localparam int TPO_GRP_WIDTH  = 4;

endpackage : tpo_pkg

// *** design/tpo_trig_sel.sv ***
// module: picks each group's compare-match strobe from the timer channels
`timescale 1ns/10ps
`default_nettype none
module tpo_trig_sel
	import tpo_pkg::*;
(
	input  wire logic [7:0]                  trig_select,
	input  wire logic [TPO_NUM_CHAN-1:0]     chan_match,
	output logic      [TPO_NUM_GROUPS-1:0]   grp_fire
);

	// ----------------------------------------------------------------
	// per group mux, bits 2g+1:2g name the channel
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < TPO_NUM_GROUPS; g++)
		begin : g_grp
			// combinational so the copy lands in the strobe's own cycle
			assign grp_fire[g] = chan_match[trig_select[2*g +: 2]];
		end
	endgenerate

endmodule : tpo_trig_sel
`default_nettype wire

// *** design/tpo_half.sv ***
// module: one 8-bit half: next-data, enable and port data register
`timescale 1ns/10ps
`default_nettype none
module tpo_half
	import tpo_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [1:0] grp_fire,
	input  wire logic       nd_we_hi,
	input  wire logic       nd_we_lo,
	input  wire logic [7:0] nd_wdata,
	input  wire logic       en_we,
	input  wire logic       port_we,
	input  wire logic [7:0] wdata,
	output logic      [7:0] next_data,
	output logic      [7:0] enable,
	output logic      [7:0] port_data
);

	typedef struct packed {
		logic [7:0] nd;
		logic [7:0] en;
		logic [7:0] pd;
	} tpo_half_t;

	tpo_half_t s_q;
	tpo_half_t s_d;
	logic [7:0] fire_bits;

	assign fire_bits = {{4{grp_fire[1]}}, {4{grp_fire[0]}}};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		if (nd_we_hi)
			s_d.nd[7:4] = nd_wdata[7:4];
		if (nd_we_lo)
			s_d.nd[3:0] = nd_wdata[3:0];
		if (en_we)
			s_d.en = wdata;
		// enabled bits are closed to software writes
		if (port_we)
			s_d.pd = (s_q.pd & s_q.en) | (wdata & ~s_q.en);
		// the transfer wins over a software write of the same bit
		s_d.pd = (s_d.pd & ~(s_q.en & fire_bits)) | (s_q.nd & s_q.en & fire_bits);
	end

	// ----------------------------------------------------------------
	// state register; software standby has no effect here
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			s_q.nd <= TPO_RST_NEXT_DATA;
			s_q.en <= TPO_RST_ENABLE;
			s_q.pd <= TPO_RST_PORT;
		end
		else
			s_q <= s_d;
	end

	assign next_data = s_q.nd;
	assign enable    = s_q.en;
	assign port_data = s_q.pd;

endmodule : tpo_half
`default_nettype wire

// *** tb/tpo_checker.sv ***
// checker: port-level assertions for the timed pattern output block
`timescale 1ns/10ps
`default_nettype none
module tpo_checker
	import tpo_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic [3:0]  chan_match,
	input wire logic [7:0]  lower_port_data,
	input wire logic [7:0]  upper_port_data
);
	logic [7:0] ts_q;
	logic [7:0] eu_q;
	logic [7:0] el_q;
	wire        sh_up = ts_q[7:6] == ts_q[5:4];
	wire        sh_lo = ts_q[3:2] == ts_q[1:0];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// shadow copies, so layout and gating can be judged from the ports alone
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			ts_q <= TPO_RST_TRIG_SEL;
			eu_q <= TPO_RST_ENABLE;
			el_q <= TPO_RST_ENABLE;
		end
		else if (reg_wr)
		begin
			if (reg_addr == TPO_ADDR_TRIG_SEL) ts_q <= reg_wdata;
			if (reg_addr == TPO_ADDR_EN_UPPER) eu_q <= reg_wdata;
			if (reg_addr == TPO_ADDR_EN_LOWER) el_q <= reg_wdata;
		end
	end
	AST_TRIG_RD: assert property (reg_rd && reg_addr == TPO_ADDR_TRIG_SEL |=> reg_rdata == $past(ts_q))
		else $error("trigger select readback wrong");
	AST_UP_SHARED: assert property (reg_rd && reg_addr == TPO_ADDR_ND_UP_2ND && sh_up |=> reg_rdata == 8'hFF)
		else $error("shared companion not all ones");
	AST_UP_SPLIT1: assert property (reg_rd && reg_addr == TPO_ADDR_ND_UP_1ST && !sh_up |=> reg_rdata[3:0] == 4'hF)
		else $error("split first low nibble not ones");
	AST_UP_SPLIT2: assert property (reg_rd && reg_addr == TPO_ADDR_ND_UP_2ND && !sh_up |=> reg_rdata[7:4] == 4'hF)
		else $error("split companion high nibble not ones");
	AST_LO_SHARED: assert property (reg_rd && reg_addr == TPO_ADDR_ND_LO_2ND && sh_lo |=> reg_rdata == 8'hFF)
		else $error("lower shared companion not all ones");
	AST_UP_HOLD: assert property (!(reg_wr && reg_addr == TPO_ADDR_PORT_UPPER) |=> ((upper_port_data ^ $past(upper_port_data)) & ~$past(eu_q)) == 8'h00)
		else $error("disabled upper bit changed");
	AST_LO_HOLD: assert property (!(reg_wr && reg_addr == TPO_ADDR_PORT_LOWER) |=> ((lower_port_data ^ $past(lower_port_data)) & ~$past(el_q)) == 8'h00)
		else $error("disabled lower bit changed");
	AST_PORT_WR: assert property (reg_wr && reg_addr == TPO_ADDR_PORT_UPPER && chan_match == 4'h0 |=> upper_port_data == (($past(upper_port_data) & $past(eu_q)) | ($past(reg_wdata) & ~$past(eu_q))))
		else $error("upper port write gating wrong");
endmodule : tpo_checker
bind tpo_top tpo_checker i_chk (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.chan_match(chan_match), .lower_port_data(lower_port_data),
	.upper_port_data(upper_port_data));
`default_nettype wire

// *** tb/tpo_timer_model.sv ***
// model: timer channels raising one-cycle compare-match strobes on request
`timescale 1ns/10ps
`default_nettype none
module tpo_timer_model
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [3:0] fire,
	output var  logic [3:0] chan_match
);
	// a request turns into a strobe one cycle later; quiet in reset like the timer
	always_ff @(posedge mclk)
		chan_match <= rstn ? fire : 4'h0;
endmodule : tpo_timer_model
`default_nettype wire

// *** tb/tb_top.sv ***
// testbench: register map, layout and transfer checks of the pattern output block
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import tpo_pkg::*;
;
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [3:0]  fire = 4'h0;
	logic [3:0]  chan_match;
	logic [7:0]  reg_rdata, lower_port_data, upper_port_data, ts, eu, el, nu, nl, pu, pl;
	int          bad_count = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [15:0] amap [9] = '{TPO_ADDR_TRIG_SEL, TPO_ADDR_EN_UPPER, TPO_ADDR_EN_LOWER,
		TPO_ADDR_ND_UP_1ST, TPO_ADDR_ND_UP_2ND, TPO_ADDR_ND_LO_1ST, TPO_ADDR_ND_LO_2ND,
		TPO_ADDR_PORT_LOWER, TPO_ADDR_PORT_UPPER};
	tpo_top i_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_match(chan_match),
		.lower_port_data(lower_port_data), .upper_port_data(upper_port_data));
	tpo_timer_model i_tmr (.mclk(mclk), .rstn(rstn), .fire(fire), .chan_match(chan_match));
	// clock and hang guard; the run needs well under 20000 cycles
	always #2.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (bad_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	// expected readback; equal select fields mean the whole byte sits at the first address
	function automatic logic [7:0] rd_exp(input logic [15:0] a);
		logic su;
		logic sl;
		su = ts[7:6] == ts[5:4];
		sl = ts[3:2] == ts[1:0];
		case (a)
			TPO_ADDR_TRIG_SEL:  return ts;
			TPO_ADDR_EN_UPPER:  return eu;
			TPO_ADDR_EN_LOWER:  return el;
			TPO_ADDR_ND_UP_1ST: return su ? nu : {nu[7:4], 4'hF};
			TPO_ADDR_ND_UP_2ND: return su ? 8'hFF : {4'hF, nu[3:0]};
			TPO_ADDR_ND_LO_1ST: return sl ? nl : {nl[7:4], 4'hF};
			TPO_ADDR_ND_LO_2ND: return sl ? 8'hFF : {4'hF, nl[3:0]};
			TPO_ADDR_PORT_LOWER: return pl;
			TPO_ADDR_PORT_UPPER: return pu;
			default:            return 8'h00;
		endcase
	endfunction : rd_exp
	// register update of the reference; enabled port bits ignore software writes
	function automatic void wr_model(input logic [15:0] a, input logic [7:0] d);
		logic su;
		logic sl;
		su = ts[7:6] == ts[5:4];
		sl = ts[3:2] == ts[1:0];
		case (a)
			TPO_ADDR_TRIG_SEL:   ts = d;
			TPO_ADDR_EN_UPPER:   eu = d;
			TPO_ADDR_EN_LOWER:   el = d;
			TPO_ADDR_ND_UP_1ST:  nu = su ? d : {d[7:4], nu[3:0]};
			TPO_ADDR_ND_UP_2ND:  nu = su ? nu : {nu[7:4], d[3:0]};
			TPO_ADDR_ND_LO_1ST:  nl = sl ? d : {d[7:4], nl[3:0]};
			TPO_ADDR_ND_LO_2ND:  nl = sl ? nl : {nl[7:4], d[3:0]};
			TPO_ADDR_PORT_LOWER: pl = (pl & el) | (d & ~el);
			TPO_ADDR_PORT_UPPER: pu = (pu & eu) | (d & ~eu);
			default:             ;
		endcase
	endfunction : wr_model
	// transfer of the reference: each nibble follows the channel its field picks
	function automatic void fire_model(input logic [3:0] m);
		logic [15:0] g;
		for (int i = 0; i < 4; i++)
			g[i*4 +: 4] = {4{m[ts[i*2 +: 2]]}};
		pl = (pl & ~(el & g[7:0])) | (nl & el & g[7:0]);
		pu = (pu & ~(eu & g[15:8])) | (nu & eu & g[15:8]);
	endfunction : fire_model
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// port data is its own kind of result, so it has its own message
	task automatic cmp_port(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: port got %h expected %h", $time, got, exp);
		end
	endtask : cmp_port
	task automatic do_reset();
		// reset is launched on an edge too, never between edges
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		{ts, eu, el, nu, nl, pu, pl} = {8'hFF, 48'h0000_0000_0000};
	endtask : do_reset
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		wr_model(a, d);
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 cmp(reg_rdata, rd_exp(a));
	endtask : rd
	// strobe goes through the timer model; ports are looked at after the transfer edge
	task automatic pulse(input logic [3:0] m);
		@(posedge mclk);
		fire <= m;
		@(posedge mclk);
		fire <= 4'h0;
		@(posedge mclk);
		#1 fire_model(m);
		cmp_port(lower_port_data, pl);
		cmp_port(upper_port_data, pu);
	endtask : pulse
	// second pass repeats everything after a reset in mid-run
	initial
	begin
		void'($urandom(43378));
		do_reset();
		for (int k = 0; k < 2; k++)
		begin
			for (int i = 0; i < 9; i++)
				rd(amap[i]);
			rd(16'h0000);
			// shared layout straight after reset: whole byte at the first address
			wr(TPO_ADDR_ND_UP_1ST, 8'h5A);
			wr(TPO_ADDR_ND_UP_2ND, 8'h11);
			wr(TPO_ADDR_ND_LO_1ST, 8'hA5);
			rd(TPO_ADDR_ND_UP_1ST);
			rd(TPO_ADDR_ND_LO_1ST);
			wr(TPO_ADDR_TRIG_SEL, 8'h1B);
			wr(TPO_ADDR_EN_UPPER, 8'hA5);
			wr(TPO_ADDR_EN_LOWER, 8'hFF);
			wr(TPO_ADDR_ND_UP_1ST, 8'hC3);
			wr(TPO_ADDR_ND_UP_2ND, 8'h3C);
			wr(TPO_ADDR_ND_LO_1ST, 8'h96);
			wr(TPO_ADDR_ND_LO_2ND, 8'h69);
			for (int i = 3; i < 7; i++)
				rd(amap[i]);
			for (int c = 0; c < 4; c++)
				pulse(4'h1 << c);
			repeat (150)
			begin
				wr(amap[$urandom_range(8)], 8'($urandom));
				rd(amap[$urandom_range(8)]);
				pulse(4'($urandom));
			end
			do_reset();
		end
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
